// ===== design/mcd_params.svh
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH
// register window
`define MCD_BASE_ADDR           32'ha000_0000
`define MCD_REG_COUNT           13
`define MCD_OFF_DRAM_CFG        32'ha000_0000
`define MCD_OFF_CAS01_W0        32'ha000_0004
`define MCD_OFF_CAS01_W1        32'ha000_0008
`define MCD_OFF_CAS01_W2        32'ha000_000c
`define MCD_OFF_STATIC_CTL0     32'ha000_0010
`define MCD_OFF_STATIC_CTL1     32'ha000_0014
`define MCD_OFF_EXP_BUS_CFG     32'ha000_0018
`define MCD_OFF_REFRESH_CTL     32'ha000_001c
`define MCD_OFF_CAS23_W0        32'ha000_0020
`define MCD_OFF_CAS23_W1        32'ha000_0024
`define MCD_OFF_CAS23_W2        32'ha000_0028
`define MCD_OFF_STATIC_CTL2     32'ha000_002c
`define MCD_OFF_SYNC_ROM_CFG    32'ha000_0030
// field positions inside dram_configuration
`define MCD_PAIR01_LSB          0
`define MCD_PAIR23_LSB          16
`define MCD_PAIR_WIDTH          8
`define MCD_EN_LSB              0
// sdram clock halve bits inside dram_refresh_control
`define MCD_REFR_HALVE01_BIT    21
`define MCD_REFR_HALVE23_BIT    22
// reset values and encodings
`define MCD_REG_RESET           32'h0000_0000
`define MCD_SIZE_WORD           2'h2
`define MCD_DIV_MEM_PHASE       2'h1
`define MCD_DIV_HALF_PHASE      2'h3
`endif

// ===== design/mcd_pkg.sv
package mcd_pkg;
   // one bank pair as laid out in its byte of dram_configuration
   typedef struct packed {
      logic       rotate_divide;  // bit 7: rotate every memory clock
      logic [2:0] row_count;      // bits 6:4: 9..15 row bits, 7 reserved
      logic       bus_width;      // bit 3: 1 is 16-bit bus
      logic       timing_type;    // bit 2: 1 is sdram
      logic [1:0] bank_enable;    // bits 1:0
   } mcd_pair_cfg_s;
   // register access from the core
   typedef struct packed {
      logic        we;
      logic [1:0]  size;          // 0 byte, 1 halfword, 2 word
      logic [31:0] addr;
      logic [31:0] wdata;
   } mcd_bus_req_s;
   // memory access request toward the dram banks
   typedef struct packed {
      logic [1:0] bank;
      logic       burst;
      logic       we;
   } mcd_mem_req_s;
endpackage : mcd_pkg

// ===== design/mcd_dram_setup.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcd_params.svh"
// Overview of operation
// - memory clock is every second cpu clock
// - registers are little endian words
// - only full word register accesses accepted
// - thirteen registers decoded from base upward
// - one enable bit per bank
// - single access to disabled bank does refresh
// - refresh counter stops when all disabled
// - hardware and sleep reset clear enables
// - other configuration bits have undefined reset
// - bit 2 selects async or sdram timing
// - bit 3 selects 32 or 16 bit bus
// - bits 6:4 give row bit count
// - bit 7 sets cas rotate rate
// - sdram clock full or half memory rate
// - disabled bank reads zero, writes dropped
// - burst read to disabled bank aborts
module mcd_dram_setup
(
   input  wire logic                  core_clk,        // cpu clock, 100 MHz
   input  wire logic                  resetn,          // hardware reset
   input  wire logic                  sleep_rst,       // sleep reset, same domain
   input  wire logic                  bus_req,         // register access strobe
   input  wire mcd_pkg::mcd_bus_req_s bus_cmd,         // register access fields
   output logic                       bus_ack,         // access completed
   output logic                       bus_err,         // access refused
   output logic [31:0]                bus_rdata,       // read data
   input  wire logic                  mem_req,         // dram access strobe
   input  wire mcd_pkg::mcd_mem_req_s mem_cmd,         // dram access fields
   output logic                       mem_go,          // normal access allowed
   output logic                       mem_cbr,         // cbr refresh to all banks
   output logic                       mem_zero_read,   // return zeros, drop writes
   output logic                       mem_abort,       // data abort
   output logic                       refresh_run,     // refresh counter enable
   output logic                       mem_clk_en,      // memory clock tick
   output logic [1:0]                 rotate_en,       // cas rotate tick per pair
   output logic [1:0]                 sdram_clk_en,    // sdram clock tick per pair
   output mcd_pkg::mcd_pair_cfg_s     pair01_cfg,      // live pair 0/1 setup
   output mcd_pkg::mcd_pair_cfg_s     pair23_cfg       // live pair 2/3 setup
);
   localparam int NREG = `MCD_REG_COUNT;

   // decode a byte address into a register index
   function automatic logic [4:0] reg_index(input logic [31:0] a);
      logic [31:0] off;
      off = a - `MCD_BASE_ADDR;
      reg_index = 5'h1f;
      if (off[31:6] == 26'h0 && off[1:0] == 2'h0 && off[5:2] < 4'hd)
         reg_index = {1'b0, off[5:2]};
   endfunction

   // register file, one flip-flop word per register
   logic [31:0] regs_reg  [NREG];
   logic [31:0] regs_next [NREG];
   logic [4:0]  idx;                 // decoded index, 1f when unmapped
   logic        word_ok;             // full word access
   logic        take;                // access accepted
   logic [1:0]  en01;                // enables of pair 0/1
   logic [1:0]  en23;                // enables of pair 2/3
   logic [3:0]  all_en;              // bank 3..0 enables
   logic [31:0] cfg_word;
   logic [31:0] refr_word;

   assign idx     = reg_index(bus_cmd.addr);
   assign word_ok = (bus_cmd.size == `MCD_SIZE_WORD);
   assign take    = bus_req && word_ok && (idx != 5'h1f);
   assign cfg_word  = regs_reg[0];
   assign refr_word = regs_reg[7];
   assign en01   = cfg_word[`MCD_PAIR01_LSB+1:`MCD_PAIR01_LSB];
   assign en23   = cfg_word[`MCD_PAIR23_LSB+1:`MCD_PAIR23_LSB];
   assign all_en = {en23, en01};

   // next register values: writes store the word as is, bit n on lane n
   always_comb
   begin
      for (int i = 0; i < NREG; i++)
      begin
         regs_next[i] = regs_reg[i];
      end
      if (take && bus_cmd.we)
      begin
         regs_next[idx[3:0]] = bus_cmd.wdata;
      end
      // sleep reset wins over a write in the same cycle
      if (sleep_rst)
      begin
         regs_next[0][`MCD_PAIR01_LSB+1:`MCD_PAIR01_LSB] = 2'h0;
         regs_next[0][`MCD_PAIR23_LSB+1:`MCD_PAIR23_LSB] = 2'h0;
      end
   end

   // register the file; undefined fields are simply zeroed at reset
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < NREG; i++)
      begin
         if (!resetn)
            regs_reg[i] <= `MCD_REG_RESET;
         else
            regs_reg[i] <= regs_next[i];
      end
   end

   // bus answer: one cycle after the strobe, ack or err
   logic        ack_next;
   logic        err_next;
   logic [31:0] rdata_next;
   always_comb
   begin
      ack_next   = take;
      err_next   = bus_req && !take;
      rdata_next = bus_rdata;
      if (take && !bus_cmd.we)
         rdata_next = regs_reg[idx[3:0]];
      else if (bus_req)
         rdata_next = 32'h0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         bus_ack   <= 1'b0;
         bus_err   <= 1'b0;
         bus_rdata <= 32'h0;
      end
      else
      begin
         bus_ack   <= ack_next;
         bus_err   <= err_next;
         bus_rdata <= rdata_next;
      end
   end

   // dram access steering by the enable of the addressed bank
   logic bank_on;
   logic go_next;
   logic cbr_next;
   logic zero_next;
   logic abort_next;
   always_comb
   begin
      bank_on    = all_en[mem_cmd.bank];
      go_next    = mem_req && bank_on;
      // a burst write to a disabled bank is handled like a single access
      cbr_next   = mem_req && !bank_on && !(mem_cmd.burst && !mem_cmd.we);
      zero_next  = cbr_next;
      abort_next = mem_req && !bank_on && mem_cmd.burst && !mem_cmd.we;
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         mem_go        <= 1'b0;
         mem_cbr       <= 1'b0;
         mem_zero_read <= 1'b0;
         mem_abort     <= 1'b0;
         refresh_run   <= 1'b0;
      end
      else
      begin
         mem_go        <= go_next;
         mem_cbr       <= cbr_next;
         mem_zero_read <= zero_next;
         mem_abort     <= abort_next;
         refresh_run   <= |{regs_next[0][17:16], regs_next[0][1:0]};
      end
   end

   // clock divider: memory clock is half the cpu rate, sdram may halve again
   logic [1:0] div_reg;
   logic [1:0] div_next;
   logic       mem_tick;
   logic       half_tick;
   logic [1:0] rot_next;
   logic [1:0] sdc_next;
   logic [1:0] halve;
   logic [1:0] cdiv;
   assign halve = {refr_word[`MCD_REFR_HALVE23_BIT], refr_word[`MCD_REFR_HALVE01_BIT]};
   assign cdiv  = {cfg_word[`MCD_PAIR23_LSB+7], cfg_word[`MCD_PAIR01_LSB+7]};
   always_comb
   begin
      div_next  = div_reg + 2'h1;
      mem_tick  = ((div_next & `MCD_DIV_MEM_PHASE) == `MCD_DIV_MEM_PHASE);
      half_tick = (div_next == `MCD_DIV_HALF_PHASE);
      for (int p = 0; p < 2; p++)
      begin
         // no divide means every cpu clock; sdram pairs rely on that
         rot_next[p] = cdiv[p] ? mem_tick : 1'b1;
         sdc_next[p] = halve[p] ? half_tick : mem_tick;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         div_reg      <= 2'h0;
         mem_clk_en   <= 1'b0;
         rotate_en    <= 2'h0;
         sdram_clk_en <= 2'h0;
      end
      else
      begin
         div_reg      <= div_next;
         mem_clk_en   <= mem_tick;
         rotate_en    <= rot_next;
         sdram_clk_en <= sdc_next;
      end
   end

   // live pair setup, straight from the register flops
   assign pair01_cfg = mcd_pkg::mcd_pair_cfg_s'(regs_reg[0][7:0]);
   assign pair23_cfg = mcd_pkg::mcd_pair_cfg_s'(regs_reg[0][23:16]);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   mem_clk_alt_a: assert property (mem_clk_en |=> !mem_clk_en ##1 mem_clk_en)
      else $error("memory clock tick not every second cycle");
   word_only_a: assert property (bus_req && bus_cmd.size != `MCD_SIZE_WORD |=> bus_err && !bus_ack)
      else $error("narrow access not refused");
   map_end_a: assert property (bus_req && word_ok && bus_cmd.addr == 32'ha000_0034 |=> bus_err)
      else $error("address past last register accepted");
   write_read_a: assert property (bus_req && take && bus_cmd.we && !sleep_rst ##1 bus_req && !bus_cmd.we
      && bus_cmd.addr == $past(bus_cmd.addr) && bus_cmd.size == `MCD_SIZE_WORD
      |=> bus_rdata == $past(bus_cmd.wdata, 2))
      else $error("read back differs from written word");
   cbr_single_a: assert property (mem_req && !all_en[mem_cmd.bank] && !mem_cmd.burst |=>
      mem_cbr && mem_zero_read && !mem_go)
      else $error("disabled bank single access without refresh");
   burst_abort_a: assert property (mem_req && !all_en[mem_cmd.bank] && mem_cmd.burst && !mem_cmd.we |=>
      mem_abort && !mem_cbr)
      else $error("burst read to disabled bank did not abort");
   refresh_stop_a: assert property (cfg_word[17:16] == 2'h0 && cfg_word[1:0] == 2'h0 && $stable(cfg_word)
      |-> !refresh_run)
      else $error("refresh runs with all banks disabled");
   sleep_clear_a: assert property (sleep_rst |=>
      pair01_cfg.bank_enable == 2'h0 && pair23_cfg.bank_enable == 2'h0)
      else $error("sleep reset left a bank enabled");
   rotate_full_a: assert property (!cdiv[0] && $stable(cdiv) |=> rotate_en[0])
      else $error("undivided rotate missed a cpu clock");
   // the halve bit must stay set over the whole gap, a rewrite in between legally restarts the rate
   sdram_half_a: assert property (halve[0] && $stable(halve) && sdram_clk_en[0] ##1 halve[0] [*2] |=>
      !sdram_clk_en[0] && !$past(sdram_clk_en[0]) && !$past(sdram_clk_en[0], 2))
      else $error("halved sdram clock ticks too often");

   refresh_cov_c: cover property (mem_req && !mem_cmd.burst ##1 mem_cbr);
   abort_cov_c:   cover property (mem_abort);
   write_cov_c:   cover property (bus_ack ##1 bus_req && !bus_cmd.we ##1 bus_ack);
   err_cov_c:     cover property (bus_err);
endmodule : mcd_dram_setup
`default_nettype wire

// ===== tb/mcd_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side dram stub: counts refreshes it receives
module mcd_dram_model
(
   input  wire logic  core_clk,  // cpu clock
   input  wire logic  resetn,    // bench reset
   input  wire logic  mem_cbr,   // cbr refresh to every bank
   output logic [7:0] cbr_seen   // refreshes seen so far
);
   // a cbr hits all banks at once, so one counter stands for all of them
   always @(posedge core_clk)
   begin
      if (!resetn)
         cbr_seen <= 8'h0;
      else if (mem_cbr)
         cbr_seen <= cbr_seen + 8'h1;
   end
endmodule // mcd_dram_model
`default_nettype wire

// ===== tb/tb_memory_config_dram_setup.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcd_params.svh"
module tb_memory_config_dram_setup;
   logic                   core_clk = 1'b0;
   logic                   resetn = 1'b0;
   logic                   sleep_rst = 1'b0;
   logic                   bus_req = 1'b0;
   logic                   mem_req = 1'b0;
   mcd_pkg::mcd_bus_req_s  bus_cmd = '0;
   mcd_pkg::mcd_mem_req_s  mem_cmd = '0;
   logic                   bus_ack, bus_err, mem_go, mem_cbr, mem_zero_read, mem_abort;
   logic                   refresh_run, mem_clk_en;
   logic [31:0]            bus_rdata, v, cfg, refr, a;
   logic [1:0]             rotate_en, sdram_clk_en;
   logic [7:0]             cbr_seen, cbr_exp;
   mcd_pkg::mcd_pair_cfg_s pair01_cfg, pair23_cfg;
   integer                 errors = 0, check_count = 0, seed = 32'hb723, cycles = 0, i, j;
   logic [31:0]            shadow [13];
   // 100 MHz clock
   always #5 core_clk = ~core_clk;
   mcd_dram_setup DUT (.core_clk(core_clk), .resetn(resetn), .sleep_rst(sleep_rst), .bus_req(bus_req),
      .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_go(mem_go), .mem_cbr(mem_cbr), .mem_zero_read(mem_zero_read),
      .mem_abort(mem_abort), .refresh_run(refresh_run), .mem_clk_en(mem_clk_en), .rotate_en(rotate_en),
      .sdram_clk_en(sdram_clk_en), .pair01_cfg(pair01_cfg), .pair23_cfg(pair23_cfg));
   mcd_dram_model far_end (.core_clk(core_clk), .resetn(resetn), .mem_cbr(mem_cbr), .cbr_seen(cbr_seen));
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard, generous against some 480 cycles of work
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one register access; answer is registered on the taking edge, read at the next negedge
   task automatic bus(input logic we, input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] d,
                      input logic err, output logic [31:0] rd);
      @(negedge core_clk);
      bus_req = 1'b1;
      bus_cmd = '{we, sz, ad, d};
      @(negedge core_clk);
      bus_req = 1'b0;
      chk("ack_err", {30'h0, !err, err}, {30'h0, bus_ack, bus_err});
      rd = bus_rdata;
   endtask
   // software side keeps the pairing rules: no rotate divide on sdram, 15 row bits only on a 16-bit bus
   function automatic logic [31:0] legal_cfg(input logic [31:0] c);
      for (int p = 0; p < 32; p += 16)
      begin
         if (c[p + 2])
            c[p + 7] = 1'b0;
         if (c[p + 4 +: 3] == 3'h6)
            c[p + 3] = 1'b1;
      end
      return c;
   endfunction
   // what one dram request must turn into: {go, cbr, zero, abort}
   function automatic logic [3:0] mem_exp(input logic [31:0] c, input logic [1:0] b, input logic bu,
                                          input logic we);
      logic en;
      logic ab;
      en = c[{b[1], 3'h0, b[0]}];
      ab = !en && bu && !we;
      return {en, !en && !ab, !en && !ab, ab};
   endfunction
   // the answer is a one-cycle pulse, so it is looked at the negedge right after the taking edge
   task automatic mem(input logic [3:0] k);
      logic [3:0] e;
      e = mem_exp(cfg, k[3:2], k[1], k[0]);
      @(negedge core_clk);
      mem_req = 1'b1;
      mem_cmd = k;
      @(negedge core_clk);
      mem_req = 1'b0;
      chk("mem", {28'h0, e}, {28'h0, mem_go, mem_cbr, mem_zero_read, mem_abort});
      if (e[2])
         cbr_exp++;
   endtask
   // count ticks over 16 cycles; every period divides 16, so phase does not matter
   task automatic ticks();
      logic [7:0] n [5];
      logic [4:0] s;
      n = '{default:8'h0};
      repeat (16)
      begin
         @(negedge core_clk);
         s = {sdram_clk_en, rotate_en, mem_clk_en};
         for (int k = 0; k < 5; k++) n[k] += {7'h0, s[k]};
      end
      chk("mem_clk", 8, n[0]);
      chk("rot01", cfg[7] ? 8 : 16, n[1]);
      chk("rot23", cfg[23] ? 8 : 16, n[2]);
      chk("sd01", refr[`MCD_REFR_HALVE01_BIT] ? 4 : 8, n[3]);
      chk("sd23", refr[`MCD_REFR_HALVE23_BIT] ? 4 : 8, n[4]);
   endtask
   initial
   begin
      cbr_exp = 8'h0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      for (i = 0; i < 13; i++)
      begin
         bus(1'b0, `MCD_SIZE_WORD, `MCD_BASE_ADDR + 4 * i, 32'h0, 1'b0, v);
         chk("reset_val", `MCD_REG_RESET, v);
         shadow[i] = $random(seed);
         bus(1'b1, `MCD_SIZE_WORD, `MCD_BASE_ADDR + 4 * i, shadow[i], 1'b0, v);
      end
      for (i = 0; i < 13; i++)
      begin
         bus(1'b0, `MCD_SIZE_WORD, `MCD_BASE_ADDR + 4 * i, 32'h0, 1'b0, v);
         chk("readback", shadow[i], v);
      end
      // back-to-back write then read of one register, strobe held up across both
      v = $random(seed);
      shadow[1] = v;
      @(negedge core_clk);
      bus_req = 1'b1;
      bus_cmd = '{1'b1, `MCD_SIZE_WORD, `MCD_OFF_CAS01_W0, v};
      @(negedge core_clk);
      bus_cmd = '{1'b0, `MCD_SIZE_WORD, `MCD_OFF_CAS01_W0, 32'h0};
      @(negedge core_clk);
      bus_req = 1'b0;
      chk("b2b_ack", 32'h1, {31'h0, bus_ack});
      chk("b2b_read", shadow[1], bus_rdata);
      $display("test register map done");
      // byte, halfword, unaligned and unmapped accesses are all refused
      for (i = 0; i < 4; i++)
      begin
         a = (i == 2) ? `MCD_BASE_ADDR + 2 : (i == 3) ? `MCD_OFF_SYNC_ROM_CFG + 4 : `MCD_BASE_ADDR;
         bus(1'b1, (i < 2) ? i[1:0] : `MCD_SIZE_WORD, a, 32'hdead_beef, 1'b1, v);
         chk("err_rdata", 32'h0, v);
         bus(1'b0, (i < 2) ? i[1:0] : `MCD_SIZE_WORD, a, 32'h0, 1'b1, v);
      end
      bus(1'b0, `MCD_SIZE_WORD, `MCD_BASE_ADDR, 32'h0, 1'b0, v);
      chk("no_write", shadow[0], v);
      $display("test refusals done");
      for (j = 0; j < 7; j++)
      begin
         cfg = (j == 0) ? 32'h0 : (j == 1) ? 32'hffff_ffff : (j == 2) ? 32'h0001_0002 : $random(seed);
         cfg = legal_cfg(cfg);
         refr = $random(seed);
         bus(1'b1, `MCD_SIZE_WORD, `MCD_OFF_REFRESH_CTL, refr, 1'b0, v);
         bus(1'b1, `MCD_SIZE_WORD, `MCD_OFF_DRAM_CFG, cfg, 1'b0, v);
         @(negedge core_clk);
         chk("pair01", {24'h0, cfg[7:0]}, {24'h0, pair01_cfg});
         chk("pair23", {24'h0, cfg[23:16]}, {24'h0, pair23_cfg});
         chk("refresh_run", {31'h0, |{cfg[17:16], cfg[1:0]}}, {31'h0, refresh_run});
         for (i = 0; i < 16; i++) mem(i[3:0]);
         ticks();
      end
      chk("cbr_count", {24'h0, cbr_exp}, {24'h0, cbr_seen});
      $display("test bank setups done");
      // sleep reset clears only the four enables
      @(negedge core_clk);
      sleep_rst = 1'b1;
      @(negedge core_clk);
      sleep_rst = 1'b0;
      bus(1'b0, `MCD_SIZE_WORD, `MCD_OFF_DRAM_CFG, 32'h0, 1'b0, v);
      chk("sleep", cfg & 32'hfffc_fffc, v);
      chk("sleep_run", 32'h0, {31'h0, refresh_run});
      $display("test sleep reset done");
      close_out();
   end
endmodule // tb_memory_config_dram_setup
`default_nettype wire
